// file: hdl/ardl_top.sv
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
// Function
// - The main relay polarity is fail safe or standard, fail safe after reset.
// - In fail safe polarity the main relay is energized with no fault and while injection is inhibited.
// - In fail safe polarity a preventive fault, special status or inoperative state de-energizes the main relay, and a fault does unless injection is inhibited.
// - In fail safe polarity an inhibited injection with a preventive fault present de-energizes the main relay.
// - A fault that was detected, acknowledged and then cleared toggles the main relay for 3 s in either polarity.
// - A relay self-test request toggles the main relay for 3 s.
// - In standard polarity any fault condition or inhibited injection energizes the main relay.
// - In standard polarity the main relay drops with no fault, or when a fault is acknowledged with acknowledge enabled.
// - The early warning relay mode is standard, fail safe or mirror, fail safe after reset.
// - In fail safe mode the early relay is energized only while no fault condition exists.
// - A relay self-test request toggles the early relay for 3 s in fail safe and standard modes.
// - In standard mode the early relay is energized on any fault condition and dropped otherwise.
// - In mirror mode the early relay copies the main relay while the device works.
// - In mirror mode an inoperative device drives the early relay opposite to the main relay.
// - An alarm rises below its threshold and clears only above 1.2 times that threshold.
module ardl_top #(
  parameter int TICK_CYCLES  = ardl_pkg::ARDL_TICK_CYCLES,
  parameter int TOGGLE_TICKS = ardl_pkg::ARDL_TOGGLE_MS
) (
  // clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  // avalon-mm slave
  input  wire logic [ardl_pkg::ARDL_AW-1:0] avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  // insulation measurement and status
  input  wire logic [15:0]        meas_i,
  input  wire logic               meas_valid_i,
  input  wire logic               special_i,
  input  wire logic               inoperative_i,
  input  wire logic               inhibit_i,
  input  wire logic               ack_i,
  // relay coils and interrupt
  output logic                    main_relay_o,
  output logic                    early_relay_o,
  output logic                    irq_o
);
  import ardl_pkg::*;

  logic        busy_q;
  logic [31:0] rdata_q;
  logic        main_std_q, ack_en_q, corr_en_q;
  ardl_emode_e emode_q;
  logic [15:0] alm_thr_q, pre_thr_q;
  logic [3:0]  istat_q, imask_q;
  logic        alarm_q, prev_q, acked_q, inop_q;
  logic [31:0] tick_cnt_q;
  logic        tick;
  logic        main_q, early_q;

  // bus handshake: every access answers on its second cycle
  wire logic acc      = avs_read_i | avs_write_i;
  wire logic done     = acc & busy_q;
  wire logic wr_done  = done & avs_write_i;
  assign avs_waitrequest_o = acc & ~busy_q;
  assign avs_readdata_o    = rdata_q;

  wire logic sel_ctrl  = avs_address_i == {1'b0, ARDL_OFF_CTRL};
  wire logic sel_stat  = avs_address_i == {1'b0, ARDL_OFF_STATUS};
  wire logic sel_istat = avs_address_i == {1'b0, ARDL_OFF_ISTAT};
  wire logic sel_imask = avs_address_i == {1'b0, ARDL_OFF_IMASK};
  wire logic sel_thr   = avs_address_i == ARDL_OFF_THR;

  // relay self-test is a write-one pulse, never stored
  wire logic test_req = wr_done & sel_ctrl & avs_writedata_i[ARDL_CTRL_TEST];

  // hysteresis compare without division: meas*5 > thr*6
  wire logic [18:0] meas5  = {3'b000, meas_i} * ARDL_HYS_DEN;
  wire logic [18:0] alm6   = {3'b000, alm_thr_q} * ARDL_HYS_NUM;
  wire logic [18:0] pre6   = {3'b000, pre_thr_q} * ARDL_HYS_NUM;
  wire logic alm_set  = meas_valid_i & (meas_i < alm_thr_q);
  wire logic alm_clr  = meas_valid_i & (meas5 > alm6);
  wire logic pre_set  = meas_valid_i & (meas_i < pre_thr_q);
  wire logic pre_clr  = meas_valid_i & (meas5 > pre6);

  ardl_cond_s cond;
  assign cond = '{inop: inoperative_i, special: special_i, fault: alarm_q, prev: prev_q};
  wire logic any_cond = |cond;

  // corrected fault: acknowledged alarm leaving on its clear threshold
  wire logic corr_start = alarm_q & alm_clr & acked_q & ack_en_q & corr_en_q;
  wire logic inop_rise  = inoperative_i & ~inop_q;

  // commanded main relay state before any toggle
  wire logic fs_main  = ~any_cond | (inhibit_i & ~prev_q & ~special_i & ~inoperative_i);
  wire logic ack_drop = alarm_q & acked_q & ack_en_q;
  wire logic std_main = (any_cond | inhibit_i) & ~ack_drop;
  wire logic main_cmd = main_std_q ? std_main : fs_main;

  // early relay commanded state per mode
  logic early_cmd;
  wire logic [1:0] tog_act;
  wire logic main_out = main_cmd ^ tog_act[0];
  always_comb begin
    unique case (emode_q)
      EM_STANDARD: early_cmd = any_cond ^ tog_act[1];
      EM_MIRROR:   early_cmd = inoperative_i ? ~main_out : main_out;
      default:     early_cmd = ~any_cond ^ tog_act[1];
    endcase
  end

  // bus handshake and read data capture
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q  <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      busy_q <= acc & ~busy_q;
      if (avs_read_i & ~busy_q) begin
        rdata_q <= sel_ctrl  ? {26'h000_0000, 1'b0, corr_en_q, ack_en_q, emode_q, main_std_q}
                 : sel_stat  ? {24'h00_0000, tog_act, inhibit_i, |cond, cond}
                 : sel_istat ? {28'h000_0000, istat_q}
                 : sel_imask ? {28'h000_0000, imask_q}
                 : sel_thr   ? {pre_thr_q, alm_thr_q}
                 : 32'h0000_0000;
      end
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_std_q <= ARDL_MAIN_STD_RST;
      emode_q    <= ARDL_EMODE_RST;
      ack_en_q   <= ARDL_ACK_EN_RST;
      corr_en_q  <= ARDL_CORR_EN_RST;
      alm_thr_q  <= ARDL_ALM_THR_RST;
      pre_thr_q  <= ARDL_PRE_THR_RST;
      imask_q    <= ARDL_IMASK_RST;
    end else if (wr_done) begin
      if (sel_ctrl) begin
        main_std_q <= avs_writedata_i[ARDL_CTRL_MAIN_STD];
        emode_q    <= ardl_emode_e'(avs_writedata_i[ARDL_CTRL_EMODE_LSB +: 2]);
        ack_en_q   <= avs_writedata_i[ARDL_CTRL_ACK_EN];
        corr_en_q  <= avs_writedata_i[ARDL_CTRL_CORR_EN];
      end
      if (sel_thr) begin
        alm_thr_q <= avs_writedata_i[15:0];
        pre_thr_q <= avs_writedata_i[31:16];
      end
      if (sel_imask) imask_q <= avs_writedata_i[3:0];
    end
  end

  // alarm latches with hysteresis; acknowledge only counts during an alarm
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_q <= 1'b0;
      prev_q  <= 1'b0;
      acked_q <= 1'b0;
      inop_q  <= 1'b0;
    end else begin
      inop_q <= inoperative_i;
      if (alm_set) alarm_q <= 1'b1;
      else if (alm_clr) alarm_q <= 1'b0;
      if (pre_set) prev_q <= 1'b1;
      else if (pre_clr) prev_q <= 1'b0;
      if (alarm_q & alm_clr & ~alm_set) acked_q <= 1'b0;
      else if (ack_i & alarm_q) acked_q <= 1'b1;
    end
  end

  // sticky events: a set in the clearing cycle wins
  wire logic [3:0] ev = {inop_rise, corr_start, pre_set & ~prev_q, alm_set & ~alarm_q};
  wire logic [3:0] w1c = (wr_done & sel_istat) ? avs_writedata_i[3:0] : 4'h0;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) istat_q <= 4'h0;
    else          istat_q <= (istat_q & ~w1c) | ev;
  end
  assign irq_o = |(istat_q & imask_q);

  // millisecond timebase; slow rates run as enables, not clocks
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)  tick_cnt_q <= 32'h0000_0000;
    else if (tick) tick_cnt_q <= 32'h0000_0000;
    else           tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
  end
  assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);

  // one toggle timer per relay: index 0 main, 1 early
  wire logic [1:0] tog_start = {test_req, test_req | corr_start};
  for (genvar g = 0; g < 2; g++) begin : g_tog
    logic [15:0] left_q;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)          left_q <= 16'h0000;
      else if (tog_start[g]) left_q <= 16'(TOGGLE_TICKS);
      else if (tick && left_q != 16'h0000) left_q <= left_q - 16'h0001;
    end
    assign tog_act[g] = left_q != 16'h0000;
  end

  // coils come from flip-flops, so no glitch reaches the relay drivers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_q  <= 1'b0;
      early_q <= 1'b0;
    end else begin
      main_q  <= main_out;
      early_q <= early_cmd;
    end
  end
  assign main_relay_o  = main_q;
  assign early_relay_o = early_q;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_fs_main_idle: assert property (!main_std_q && !any_cond && tog_act == 2'b00 |=> main_q)
    else $error("fail safe main relay not energized without fault");
  a_fs_main_fault: assert property (!main_std_q && (alarm_q || inoperative_i) && !tog_act[0]
                                    |=> !main_q)
    else $error("fail safe main relay energized on fault");
  a_fs_inhibit_prev: assert property (!main_std_q && inhibit_i && prev_q && !tog_act[0]
                                      |=> !main_q)
    else $error("inhibit with preventive fault left main relay on");
  a_std_main_on: assert property (main_std_q && inhibit_i && !ack_drop && !tog_act[0]
                                  |=> main_q)
    else $error("standard main relay not energized on inhibit");
  a_std_ack_drop: assert property (main_std_q && ack_drop && !tog_act[0] |=> !main_q)
    else $error("acknowledged standard main relay still energized");
  a_test_toggle: assert property (test_req |=> tog_act == 2'b11)
    else $error("self test did not start both toggles");
  a_corr_toggle: assert property (corr_start |=> tog_act[0] && !alarm_q)
    else $error("corrected fault signal not started");
  a_mirror_copy: assert property (emode_q == EM_MIRROR && !inoperative_i
                                  |=> early_relay_o == main_relay_o)
    else $error("mirror relay differs while operating");
  a_mirror_inop: assert property (emode_q == EM_MIRROR && inoperative_i
                                  |=> early_relay_o != main_relay_o)
    else $error("mirror relay still copies when inoperative");
  a_early_fs: assert property (emode_q == EM_FAIL_SAFE && !tog_act[1]
                               |=> early_q == !$past(any_cond))
    else $error("fail safe early relay wrong");
  a_early_std: assert property (emode_q == EM_STANDARD && !tog_act[1]
                                |=> early_q == $past(any_cond))
    else $error("standard early relay wrong");
  a_hyst_hold: assert property (alarm_q && !alm_clr |=> alarm_q)
    else $error("alarm cleared inside hysteresis band");
  a_toggle_invert: assert property (tog_act[0] |=> main_q == !$past(main_cmd))
    else $error("toggle did not invert main relay");

  c_test_run:  cover property (test_req ##1 tog_act[0] [*8]);
  c_corr_run:  cover property (ack_i && alarm_q ##[1:100] corr_start);
  c_mirror:    cover property (emode_q == EM_MIRROR && inoperative_i);
  c_irq:       cover property (irq_o);

endmodule : ardl_top

// file: shared/ardl_pkg.sv
package ardl_pkg;

  // register byte offsets on the avalon slave
  localparam logic [3:0] ARDL_OFF_CTRL   = 4'h0;
  localparam logic [3:0] ARDL_OFF_STATUS = 4'h4;
  localparam logic [3:0] ARDL_OFF_ISTAT  = 4'h8;
  localparam logic [3:0] ARDL_OFF_IMASK  = 4'hC;
  localparam int         ARDL_AW         = 5;
  localparam logic [4:0] ARDL_OFF_THR    = 5'h10;

  // control register fields
  localparam int ARDL_CTRL_MAIN_STD  = 0;
  localparam int ARDL_CTRL_EMODE_LSB = 1;
  localparam int ARDL_CTRL_ACK_EN    = 3;
  localparam int ARDL_CTRL_CORR_EN   = 4;
  localparam int ARDL_CTRL_TEST      = 5;

  // early warning relay modes
  typedef enum logic [1:0] {
    EM_FAIL_SAFE = 2'b00,
    EM_STANDARD  = 2'b01,
    EM_MIRROR    = 2'b10
  } ardl_emode_e;

  // reset values: fail safe polarity, acknowledge enabled, corrected signal off
  localparam logic        ARDL_MAIN_STD_RST = 1'b0;
  localparam ardl_emode_e ARDL_EMODE_RST    = EM_FAIL_SAFE;
  localparam logic        ARDL_ACK_EN_RST   = 1'b1;
  localparam logic        ARDL_CORR_EN_RST  = 1'b0;
  localparam logic [15:0] ARDL_ALM_THR_RST  = 16'h0001;
  localparam logic [15:0] ARDL_PRE_THR_RST  = 16'h0000;  // zero means off
  localparam logic [3:0]  ARDL_IMASK_RST    = 4'h0;

  // hysteresis: clear above 6/5 of threshold
  localparam logic [18:0] ARDL_HYS_NUM = 19'h0_0006;
  localparam logic [18:0] ARDL_HYS_DEN = 19'h0_0005;

  // interrupt status bit positions
  localparam int ARDL_EV_ALARM = 0;
  localparam int ARDL_EV_PREV  = 1;
  localparam int ARDL_EV_CORR  = 2;
  localparam int ARDL_EV_INOP  = 3;

  // timing: millisecond timebase and a 3 s toggle
  localparam int ARDL_CLK_PERIOD_NS = 4;
  localparam int ARDL_TICK_NS       = 1000000;
  localparam int ARDL_TICK_CYCLES   = ARDL_TICK_NS / ARDL_CLK_PERIOD_NS;
  localparam int ARDL_TOGGLE_MS     = 3000;

  // insulation condition carried as one group
  typedef struct packed {
    logic inop;
    logic special;
    logic fault;
    logic prev;
  } ardl_cond_s;

endpackage : ardl_pkg

// file: test/ardl_relay_reader.sv
`timescale 1ns/10ps
// plc side: normally open contacts, closed while the coil is energized
module ardl_relay_reader (
  // relay coils
  input  wire logic main_relay_i,
  input  wire logic early_relay_i,
  // contact levels seen by the plc
  output logic      main_closed_o,
  output logic      early_closed_o
);
  // passive reader, the plc never drives the coils
  assign main_closed_o  = main_relay_i;
  assign early_closed_o = early_relay_i;
endmodule : ardl_relay_reader

// file: test/ardl_top_tb_top.sv
`timescale 1ns/10ps
module ardl_top_tb_top;
  import ardl_pkg::*;
  localparam int TICKS = 4;
  localparam int TOG   = 5;
  localparam int LIMIT = 6000;
  logic               ref_clk, rst_n, rd_en, wr_en, wait_req, valid;
  logic [ARDL_AW-1:0] addr;
  logic [31:0]        wdata, rdata, rv;
  logic [15:0]        meas;
  logic               special, inop, inhibit, ack, main_relay, early_relay, irq;
  logic               main_closed, early_closed;
  int                 n_mismatch, total_checks, cycles;

  ardl_top #(.TICK_CYCLES(TICKS), .TOGGLE_TICKS(TOG)) dut (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd_en),
    .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .meas_i(meas), .meas_valid_i(valid),
    .special_i(special), .inoperative_i(inop), .inhibit_i(inhibit), .ack_i(ack),
    .main_relay_o(main_relay), .early_relay_o(early_relay), .irq_o(irq));

  ardl_relay_reader plc (.main_relay_i(main_relay), .early_relay_i(early_relay),
    .main_closed_o(main_closed), .early_closed_o(early_closed));

  // 250 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // hang guard, counts as a mismatch
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= wr;
    rd_en <= ~wr;
    @(posedge ref_clk);
    while (wait_req !== 1'b0) @(posedge ref_clk);
    rv = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rv, exp);
  endtask : rdchk

  // flags are {ack, inhibit, inoperative, special}; settle covers latch plus relay register
  task automatic setin(input logic [15:0] m, input logic [3:0] f);
    @(posedge ref_clk);
    meas    <= m;
    special <= f[0];
    inop    <= f[1];
    inhibit <= f[2];
    ack     <= f[3];
    repeat (4) @(posedge ref_clk);
  endtask : setin

  task automatic relays(input logic m, input logic e);
    chk({31'h0, main_closed}, {31'h0, m});
    chk({31'h0, early_closed}, {31'h0, e});
  endtask : relays

  initial begin
    n_mismatch = 0;
    total_checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    {rd_en, wr_en, special, inop, inhibit, ack} = 6'h00;
    addr = '0;
    wdata = '0;
    meas = 16'hFFFF;
    valid = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, fail safe defaults
    rdchk(ARDL_OFF_CTRL, 32'h0000_0008);
    rdchk(ARDL_OFF_THR, 32'h0000_0001);
    rdchk(ARDL_OFF_IMASK, 32'h0000_0000);
    relays(1'b1, 1'b1);
    // invalid measurement must not latch an alarm, even at zero
    valid <= 1'b0;
    setin(16'h0000, 4'h0);
    relays(1'b1, 1'b1);
    setin(16'hFFFF, 4'h0);
    valid <= 1'b1;
    // unmapped place reads zero and ignores writes
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    rdchk(5'h14, 32'h0000_0000);
    // alarm below 100, preventive below 200
    bus(1'b1, ARDL_OFF_THR, 32'h00C8_0064);
    setin(16'h0096, 4'h0);
    relays(1'b0, 1'b0);
    setin(16'h0032, 4'h0);
    rdchk(ARDL_OFF_STATUS, 32'h0000_0013);
    // 110 is above threshold but within hysteresis, 125 clears
    setin(16'h006E, 4'h0);
    rdchk(ARDL_OFF_STATUS, 32'h0000_0013);
    setin(16'h007D, 4'h0);
    rdchk(ARDL_OFF_STATUS, 32'h0000_0011);
    setin(16'h03E8, 4'h1);
    relays(1'b0, 1'b0);
    setin(16'h03E8, 4'h2);
    relays(1'b0, 1'b0);
    setin(16'h03E8, 4'h4);
    chk({31'h0, main_closed}, 32'h0000_0001);
    setin(16'h0096, 4'h4);
    chk({31'h0, main_closed}, 32'h0000_0000);
    // standard main polarity, early stays fail safe
    bus(1'b1, ARDL_OFF_CTRL, 32'h0000_0009);
    setin(16'h03E8, 4'h0);
    relays(1'b0, 1'b1);
    setin(16'h0096, 4'h0);
    relays(1'b1, 1'b0);
    setin(16'h03E8, 4'h4);
    chk({31'h0, main_closed}, 32'h0000_0001);
    setin(16'h0032, 4'h0);
    chk({31'h0, main_closed}, 32'h0000_0001);
    setin(16'h0032, 4'h8);
    chk({31'h0, main_closed}, 32'h0000_0000);
    // early relay in standard mode
    bus(1'b1, ARDL_OFF_CTRL, 32'h0000_000A);
    setin(16'h0032, 4'h0);
    relays(1'b0, 1'b1);
    setin(16'h03E8, 4'h0);
    relays(1'b1, 1'b0);
    // mirror mode follows main until inoperative
    bus(1'b1, ARDL_OFF_CTRL, 32'h0000_000C);
    setin(16'h0032, 4'h0);
    relays(1'b0, 1'b0);
    setin(16'h03E8, 4'h0);
    relays(1'b1, 1'b1);
    setin(16'h03E8, 4'h2);
    relays(1'b0, 1'b1);
    // relay self test in fail safe, both toggle then return
    bus(1'b1, ARDL_OFF_CTRL, 32'h0000_0028);
    setin(16'h03E8, 4'h0);
    bus(1'b1, ARDL_OFF_CTRL, 32'h0000_0028);
    repeat (2) @(posedge ref_clk);
    relays(1'b0, 1'b0);
    rdchk(ARDL_OFF_STATUS, 32'h0000_00C0);
    repeat (TOG * TICKS + 10) @(posedge ref_clk);
    relays(1'b1, 1'b1);
    rdchk(ARDL_OFF_CTRL, 32'h0000_0008);
    // corrected fault signal with its interrupt
    bus(1'b1, ARDL_OFF_CTRL, 32'h0000_0018);
    bus(1'b1, ARDL_OFF_ISTAT, 32'h0000_000F);
    bus(1'b1, ARDL_OFF_IMASK, 32'h0000_0004);
    chk({31'h0, irq}, 32'h0000_0000);
    setin(16'h0032, 4'h0);
    setin(16'h0032, 4'h8);
    setin(16'h0032, 4'h0);
    setin(16'h03E8, 4'h0);
    chk({31'h0, main_closed}, 32'h0000_0000);
    rdchk(ARDL_OFF_STATUS, 32'h0000_0040);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, ARDL_OFF_ISTAT, 32'h0000_0004);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    repeat (TOG * TICKS + 10) @(posedge ref_clk);
    chk({31'h0, main_closed}, 32'h0000_0001);
    print_verdict();
  end
endmodule : ardl_top_tb_top
